// [core/timer_waveform_output_unit.sv]
/*
 * Counter, compare channels A and B, waveform output states and pin override
 * of an 8-bit timer. Assumes TICK_I is the one-cycle timer clock enable from
 * the prescaler, and that the port logic supplies value and direction bits.
 */
`timescale 1ns/100ps
`include "wave_map.svh"

module timer_waveform_output_unit
	import wave_pkg::*;
(
	// clock and reset
	input  logic       CLK_SYS_I,
	input  logic       RESETN_I,
	// timer clock enable
	input  logic       TICK_I,
	// register bus
	input  reg_req_t   BUS_I,
	output logic [7:0] RDATA_O,
	// general port bits per channel
	input  logic [1:0] PORT_VAL_I,
	input  logic [1:0] PORT_DIR_I,
	// pin drive per channel
	output logic [1:0] PIN_O,
	output logic [1:0] PIN_OE_O,
	// flags toward the flag register
	output logic       OVF_FLAG_O,
	output logic [1:0] CMP_FLAG_O
);

	state_t     s_reg;
	state_t     s_next;
	seq_t       seq;
	logic [7:0] top;
	logic       wrap;
	logic       ovf_set;
	logic       cnt_wr;
	logic       force_wr;
	logic       flag_wr;
	logic [1:0] match;
	logic [1:0] hit;

	// next output state from action, match and bottom events
	function automatic logic oc_step(input logic [1:0] com, input logic fast,
		input logic hit_i, input logic wrap_i, input logic cur);
		logic r;
		r = cur;
		if (hit_i)
		begin
			case (com)
				`COM_TOGGLE: r = ~cur;
				`COM_CLEAR:  r = 1'b0;
				`COM_SET:    r = 1'b1;
				default:     r = cur;
			endcase
		end
		// bottom wins so compare at MAX gives a constant level
		if (fast && wrap_i)
		begin
			if (com == `COM_CLEAR)
				r = 1'b1;
			else if (com == `COM_SET)
				r = 1'b0;
		end
		return r;
	endfunction

	// sequence class from the waveform field only
	always_comb
	begin
		case (s_reg.wgm)
			`WGM_CLEAR_MATCH: seq = SEQ_CLEAR_MATCH;
			`WGM_FAST_MAX:    seq = SEQ_FAST;
			`WGM_FAST_CMP_A:  seq = SEQ_FAST;
			default:          seq = SEQ_NORMAL;
		endcase
	end

	// count events
	always_comb
	begin
		top = (s_reg.wgm == `WGM_FAST_CMP_A) ? s_reg.ocr_act[0] : `COUNT_MAX;
		cnt_wr = BUS_I.wr && (BUS_I.addr == `ADDR_COUNT);
		force_wr = BUS_I.wr && (BUS_I.addr == `ADDR_FORCE) && (seq != SEQ_FAST);
		flag_wr = BUS_I.wr && (BUS_I.addr == `ADDR_FLAGS);
		wrap = TICK_I && (((seq == SEQ_FAST) && (s_reg.cnt == top)) ||
			((seq == SEQ_CLEAR_MATCH) && (s_reg.cnt == s_reg.ocr_act[0])));
		// clear-on-match past a lowered top runs through MAX
		ovf_set = TICK_I && ((seq == SEQ_FAST) ? (s_reg.cnt == top)
			: (s_reg.cnt == `COUNT_MAX));
		for (int i = 0; i < 2; i++)
		begin
			// a pending counter write swallows this tick's match
			match[i] = TICK_I && !s_reg.blk && (s_reg.cnt == s_reg.ocr_act[i]);
			hit[i] = match[i] || (force_wr && BUS_I.wdata[i]);
		end
	end

	// next state
	always_comb
	begin
		s_next = s_reg;
		s_next.rdata = `RST_BYTE;
		if (TICK_I)
		begin
			s_next.blk = 1'b0;
			s_next.cnt = wrap ? `COUNT_BOTTOM : s_reg.cnt + 8'h01;
		end
		if (wrap && (seq == SEQ_FAST))
			s_next.ocr_act = s_reg.ocr_buf;
		for (int i = 0; i < 2; i++)
		begin
			// action read from the live mode field at the match itself
			s_next.oc[i] = oc_step(s_reg.com[i], seq == SEQ_FAST, hit[i], wrap,
				s_reg.oc[i]);
			s_next.ocf[i] = match[i] || (s_reg.ocf[i] &&
				!(flag_wr && BUS_I.wdata[`FLAG_CMP_A_BIT + i]));
			s_next.pin[i] = (s_reg.com[i] != `COM_NONE) ? s_reg.oc[i]
				: PORT_VAL_I[i];
			s_next.oe[i] = PORT_DIR_I[i];
		end
		// set wins over a clear in the same cycle
		s_next.tov = ovf_set || (s_reg.tov && !(flag_wr && BUS_I.wdata[`FLAG_OVF_BIT]));
		if (BUS_I.wr)
		begin
			if (BUS_I.addr == `ADDR_CTRL)
			begin
				s_next.wgm = BUS_I.wdata[`CTRL_WGM_LSB +: 3];
				s_next.com[0] = BUS_I.wdata[`CTRL_COM_A_LSB +: 2];
				s_next.com[1] = BUS_I.wdata[`CTRL_COM_B_LSB +: 2];
			end
			else if (BUS_I.addr == `ADDR_COUNT)
			begin
				s_next.cnt = BUS_I.wdata;
				s_next.blk = 1'b1;
			end
			else if ((BUS_I.addr == `ADDR_CMP_A) || (BUS_I.addr == `ADDR_CMP_B))
			begin
				// even address is channel A, odd address is channel B
				s_next.ocr_buf[BUS_I.addr[0]] = BUS_I.wdata;
				if (seq != SEQ_FAST)
					s_next.ocr_act[BUS_I.addr[0]] = BUS_I.wdata;
			end
		end
		if (BUS_I.rd)
		begin
			if (BUS_I.addr == `ADDR_CTRL)
				s_next.rdata = {s_reg.com[1], s_reg.com[0], 1'b0, s_reg.wgm};
			else if (BUS_I.addr == `ADDR_COUNT)
				s_next.rdata = s_reg.cnt;
			else if (BUS_I.addr == `ADDR_CMP_A)
				s_next.rdata = s_reg.ocr_buf[0];
			else if (BUS_I.addr == `ADDR_CMP_B)
				s_next.rdata = s_reg.ocr_buf[1];
			else if (BUS_I.addr == `ADDR_FLAGS)
				s_next.rdata = {5'h00, s_reg.ocf, s_reg.tov};
			else if (BUS_I.addr == `ADDR_STATUS)
				s_next.rdata = {5'h00, s_reg.blk, s_reg.oc};
			else
				s_next.rdata = `RST_BYTE;
		end
	end

	// state register
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign RDATA_O    = s_reg.rdata;
	assign PIN_O      = s_reg.pin;
	assign PIN_OE_O   = s_reg.oe;
	assign OVF_FLAG_O = s_reg.tov;
	assign CMP_FLAG_O = s_reg.ocf;

	// checks on the registered behaviour
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);

	property p_pin_source;
		s_reg.com[0] != `COM_NONE |=> PIN_O[0] == $past(s_reg.oc[0]);
	endproperty
	a_pin_source: assert property (p_pin_source)
		else $error("pin A not driven by output state");

	// sampled reset in the antecedent skips the release edge, where the flop still held 0
	property p_pin_dir;
		RESETN_I |=> PIN_OE_O == $past(PORT_DIR_I);
	endproperty
	a_pin_dir: assert property (p_pin_dir)
		else $error("pin enable differs from port direction");

	property p_mode_zero_holds;
		TICK_I && s_reg.com[1] == `COM_NONE |=> $stable(s_reg.oc[1]);
	endproperty
	a_mode_zero_holds: assert property (p_mode_zero_holds)
		else $error("output state moved with mode zero");

	property p_normal_ovf;
		TICK_I && s_reg.wgm == `WGM_NORMAL && s_reg.cnt == `COUNT_MAX && !cnt_wr
			|=> s_reg.tov && s_reg.cnt == `COUNT_BOTTOM;
	endproperty
	a_normal_ovf: assert property (p_normal_ovf)
		else $error("normal wrap without overflow flag");

	property p_ctc_clear;
		TICK_I && s_reg.wgm == `WGM_CLEAR_MATCH && s_reg.cnt == s_reg.ocr_act[0]
			&& !cnt_wr |=> s_reg.cnt == `COUNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear)
		else $error("counter not cleared at compare A");

	property p_fast_top;
		TICK_I && seq == SEQ_FAST && s_reg.cnt == top && !cnt_wr
			|=> s_reg.cnt == `COUNT_BOTTOM && s_reg.tov;
	endproperty
	a_fast_top: assert property (p_fast_top)
		else $error("fast mode did not restart at top");

	property p_fast_set_bottom;
		wrap && seq == SEQ_FAST && s_reg.com[0] == `COM_CLEAR |=> s_reg.oc[0];
	endproperty
	a_fast_set_bottom: assert property (p_fast_set_bottom)
		else $error("non-inverted output not set at bottom");

	property p_cmp_flag;
		TICK_I && !s_reg.blk && s_reg.cnt == s_reg.ocr_act[1] |=> s_reg.ocf[1];
	endproperty
	a_cmp_flag: assert property (p_cmp_flag)
		else $error("compare flag missed a match");

	property p_block;
		cnt_wr ##1 (TICK_I && !s_reg.ocf[0]) |=> !s_reg.ocf[0];
	endproperty
	a_block: assert property (p_block)
		else $error("match not blocked after counter write");

	property p_force;
		force_wr && BUS_I.wdata[0] && s_reg.com[0] == `COM_SET |=> s_reg.oc[0];
	endproperty
	a_force: assert property (p_force)
		else $error("force strobe did not set output");

	property p_fast_buffer;
		seq == SEQ_FAST && BUS_I.wr && BUS_I.addr == `ADDR_CMP_B && !wrap
			|=> $stable(s_reg.ocr_act[1]);
	endproperty
	a_fast_buffer: assert property (p_fast_buffer)
		else $error("fast mode compare write not buffered");

	property p_pin_port_b;
		RESETN_I && s_reg.com[1] == `COM_NONE |=> PIN_O[1] == $past(PORT_VAL_I[1]);
	endproperty
	a_pin_port_b: assert property (p_pin_port_b)
		else $error("pin B not driven by port value");

	property p_pin_source_b;
		s_reg.com[1] != `COM_NONE |=> PIN_O[1] == $past(s_reg.oc[1]);
	endproperty
	a_pin_source_b: assert property (p_pin_source_b)
		else $error("pin B override depends on more than its mode");

	property p_normal_count;
		TICK_I && seq == SEQ_NORMAL && s_reg.cnt != `COUNT_MAX && !cnt_wr
			|=> s_reg.cnt == $past(s_reg.cnt) + 8'h01;
	endproperty
	a_normal_count: assert property (p_normal_count)
		else $error("normal mode did not count up");

	property p_ovf_sticky;
		s_reg.tov && !(flag_wr && BUS_I.wdata[`FLAG_OVF_BIT]) |=> s_reg.tov;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow flag cleared without software");

	property p_cnt_write;
		cnt_wr |=> s_reg.cnt == $past(BUS_I.wdata);
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("counter write lost");

	property p_ctc_unbuffered;
		seq != SEQ_FAST && BUS_I.wr && BUS_I.addr == `ADDR_CMP_A
			|=> s_reg.ocr_act[0] == $past(BUS_I.wdata);
	endproperty
	a_ctc_unbuffered: assert property (p_ctc_unbuffered)
		else $error("compare A write not applied directly");

	property p_ctc_toggle;
		TICK_I && s_reg.wgm == `WGM_CLEAR_MATCH && !s_reg.blk
			&& s_reg.cnt == s_reg.ocr_act[0] && s_reg.com[0] == `COM_TOGGLE
			|=> s_reg.oc[0] != $past(s_reg.oc[0]);
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle)
		else $error("channel A did not toggle on match");

	property p_ctc_ovf;
		TICK_I && s_reg.wgm == `WGM_CLEAR_MATCH && s_reg.cnt == `COUNT_MAX && !cnt_wr
			|=> s_reg.tov && s_reg.cnt == `COUNT_BOTTOM;
	endproperty
	a_ctc_ovf: assert property (p_ctc_ovf)
		else $error("clear-on-match wrap without overflow flag");

	property p_fast_max_count;
		TICK_I && s_reg.wgm == `WGM_FAST_MAX && s_reg.cnt != `COUNT_MAX && !cnt_wr
			|=> s_reg.cnt == $past(s_reg.cnt) + 8'h01;
	endproperty
	a_fast_max_count: assert property (p_fast_max_count)
		else $error("fast mode left the count early");

	property p_fast_clear_match;
		TICK_I && seq == SEQ_FAST && !s_reg.blk && s_reg.cnt == s_reg.ocr_act[0]
			&& s_reg.cnt != top && s_reg.com[0] == `COM_CLEAR |=> !s_reg.oc[0];
	endproperty
	a_fast_clear_match: assert property (p_fast_clear_match)
		else $error("non-inverted output not cleared at match");

	property p_fast_clear_bottom;
		wrap && seq == SEQ_FAST && s_reg.com[0] == `COM_SET |=> !s_reg.oc[0];
	endproperty
	a_fast_clear_bottom: assert property (p_fast_clear_bottom)
		else $error("inverted output not cleared at bottom");

	property p_fast_max_level;
		TICK_I && seq == SEQ_FAST && s_reg.cnt == top && s_reg.ocr_act[0] == top
			&& s_reg.com[0] == `COM_CLEAR |=> s_reg.oc[0];
	endproperty
	a_fast_max_level: assert property (p_fast_max_level)
		else $error("compare at top broke the constant level");

	property p_fast_toggle;
		TICK_I && seq == SEQ_FAST && !s_reg.blk && s_reg.cnt == s_reg.ocr_act[1]
			&& s_reg.com[1] == `COM_TOGGLE |=> s_reg.oc[1] != $past(s_reg.oc[1]);
	endproperty
	a_fast_toggle: assert property (p_fast_toggle)
		else $error("fast mode toggle missed a match");

	property p_cmp_flag_a;
		TICK_I && !s_reg.blk && s_reg.cnt == s_reg.ocr_act[0] |=> s_reg.ocf[0];
	endproperty
	a_cmp_flag_a: assert property (p_cmp_flag_a)
		else $error("compare A flag missed a match");

	property p_fast_load;
		wrap && seq == SEQ_FAST |=> s_reg.ocr_act == $past(s_reg.ocr_buf);
	endproperty
	a_fast_load: assert property (p_fast_load)
		else $error("compare buffers not loaded at bottom");

	// main scenarios
	c_ctc_toggle: cover property (s_reg.wgm == `WGM_CLEAR_MATCH && hit[0]
		##1 $changed(s_reg.oc[0]));
	c_fast_pwm: cover property (seq == SEQ_FAST && wrap && s_reg.com[1] == `COM_SET);
	c_force: cover property (force_wr ##1 $changed(s_reg.oc));
	c_blocked: cover property (cnt_wr ##1 (TICK_I && s_reg.cnt == s_reg.ocr_act[0]));

endmodule

// [core/wave_map.svh]
/*
 * Register offsets, field positions, reset values and mode codes of the
 * timer waveform output unit. Assumes a 3-bit word address on the plain bus.
 */
// Behaviour
// - nonzero output mode overrides port pin value
// - port direction bit still controls pin enable
// - override ignores waveform mode
// - output state presettable and held until changed
// - output mode zero leaves output state alone
// - new output mode acts at next match
// - force strobe applies action immediately, non-PWM
// - waveform mode alone selects counting sequence
// - normal mode counts up, wraps FF to 00
// - normal mode overflow flag set on zero
// - clear-on-match mode clears counter at compare A
// - compare A unbuffered there, missed match wraps
// - clear-on-match mode one toggles channel A
// - clear-on-match overflow set going MAX to 00
// - fast modes count zero to top, restart
// - fast counter hits top, zero next tick
// - fast two clears on match, sets bottom
// - fast overflow flag set at top
// - fast compare writes go to buffer
// - compare zero spikes, MAX gives constant level
// - match sets compare flag next tick
// - PWM buffers compare values, load at bottom
// - counter write blocks next tick's match
`ifndef WAVE_MAP_SVH
`define WAVE_MAP_SVH

// word addresses
`define ADDR_CTRL        3'h0
`define ADDR_COUNT       3'h1
`define ADDR_CMP_A       3'h2
`define ADDR_CMP_B       3'h3
`define ADDR_FLAGS       3'h4
`define ADDR_FORCE       3'h5
`define ADDR_STATUS      3'h6

// control register fields
`define CTRL_WGM_LSB     0
`define CTRL_COM_A_LSB   4
`define CTRL_COM_B_LSB   6

// flag register fields
`define FLAG_OVF_BIT     0
`define FLAG_CMP_A_BIT   1
`define FLAG_CMP_B_BIT   2

// waveform mode codes
`define WGM_NORMAL       3'h0
`define WGM_CLEAR_MATCH  3'h2
`define WGM_FAST_MAX     3'h3
`define WGM_FAST_CMP_A   3'h7

// output mode codes
`define COM_NONE         2'h0
`define COM_TOGGLE       2'h1
`define COM_CLEAR        2'h2
`define COM_SET          2'h3

// counter limits and reset values
`define COUNT_MAX        8'hFF
`define COUNT_BOTTOM     8'h00
`define RST_BYTE         8'h00

`endif

// [core/wave_pkg.sv]
/*
 * Types of the timer waveform output unit.
 * Assumes wave_map.svh is available on the include path.
 */
package wave_pkg;

	// register bus request
	typedef struct packed
	{
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// counting sequence class
	typedef enum logic [1:0] {SEQ_NORMAL, SEQ_CLEAR_MATCH, SEQ_FAST} seq_t;

	// whole state of the unit
	typedef struct packed
	{
		logic [2:0]      wgm;
		logic [1:0][1:0] com;
		logic [7:0]      cnt;
		logic [1:0][7:0] ocr_buf;
		logic [1:0][7:0] ocr_act;
		logic            tov;
		logic [1:0]      ocf;
		logic [1:0]      oc;
		logic            blk;
		logic [7:0]      rdata;
		logic [1:0]      pin;
		logic [1:0]      oe;
	} state_t;

endpackage

// [tb/pin_load.sv]
/*
 * Port pin and external load model for the two timer channels.
 * Assumes pin value and enable come straight from the timer unit.
 */
`timescale 1ns/100ps

module pin_load
(
	// clock
	input  wire logic       clk_i,
	// pin drive from the timer unit
	input  wire logic [1:0] pin_i,
	input  wire logic [1:0] oe_i,
	// level seen at the pad
	output logic      [1:0] pad_o
);
	// no pull on the pad, so a released pad must not keep its old level
	initial
	begin
		pad_o = 2'h0;
		forever
		begin
			@(posedge clk_i);
			for (int c = 0; c < 2; c++)
				pad_o[c] <= oe_i[c] ? pin_i[c] : ~pad_o[c];
		end
	end
endmodule

// [tb/testbench.sv]
/*
 * Self-checking bench for the timer waveform output unit.
 * Assumes one 125 MHz clock; ticks, bus and port bits driven here.
 */
`timescale 1ns/100ps
`include "wave_map.svh"

module testbench
	import wave_pkg::*;
;
	logic       clk;
	logic       rst_n;
	logic       tick;
	reg_req_t   bus;
	logic [7:0] rdata;
	logic [1:0] pval;
	logic [1:0] pdir;
	logic [1:0] pin;
	logic [1:0] oe;
	logic [1:0] pad;
	logic [1:0] cflg;
	logic       ovf;
	int         failures;
	int         cmp_count;

	timer_waveform_output_unit u_timer_waveform_output_unit (
		.CLK_SYS_I(clk), .RESETN_I(rst_n), .TICK_I(tick), .BUS_I(bus),
		.RDATA_O(rdata), .PORT_VAL_I(pval), .PORT_DIR_I(pdir), .PIN_O(pin),
		.PIN_OE_O(oe), .OVF_FLAG_O(ovf), .CMP_FLAG_O(cflg));

	pin_load u_pin_load (.clk_i(clk), .pin_i(pin), .oe_i(oe), .pad_o(pad));

	// 8 ns system clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
	endtask

	// n timer ticks back to back
	task automatic run(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
	endtask

	// preset by force, then override against the port value
	task automatic t_pin;
		wr(`ADDR_CTRL, 8'h30);
		wr(`ADDR_FORCE, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({3'h0, pad[0], oe, pin}, 8'h17);
		wr(`ADDR_CTRL, 8'h20);
		wr(`ADDR_FORCE, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({3'h0, pad[0], oe, pin}, 8'h06);
		rd(`ADDR_STATUS, 8'h00);
	endtask

	task automatic t_norm;
		wr(`ADDR_COUNT, 8'hFE);
		run(1);
		rd(`ADDR_COUNT, 8'hFF);
		rd(`ADDR_FLAGS, 8'h00);
		run(1);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_FLAGS, 8'h01);
		chk({7'h00, ovf}, 8'h01);
		wr(`ADDR_FLAGS, 8'h07);
	endtask

	// first tick after the count write must not match channel B at zero
	task automatic t_ctc;
		wr(`ADDR_CTRL, 8'h12);
		wr(`ADDR_CMP_A, 8'h03);
		wr(`ADDR_COUNT, 8'h00);
		run(4);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_FLAGS, 8'h02);
		chk({6'h00, cflg}, 8'h01);
		rd(`ADDR_STATUS, 8'h01);
		wr(`ADDR_COUNT, 8'hFE);
		run(2);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_FLAGS, 8'h03);
		wr(`ADDR_FLAGS, 8'h07);
	endtask

	task automatic t_fast;
		pval <= 2'b00;
		wr(`ADDR_CTRL, 8'h23);
		wr(`ADDR_CMP_A, 8'h80);
		wr(`ADDR_COUNT, 8'h01);
		run(3);
		rd(`ADDR_FLAGS, 8'h02);
		rd(`ADDR_STATUS, 8'h00);
		wr(`ADDR_COUNT, 8'hFE);
		run(2);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_FLAGS, 8'h03);
		rd(`ADDR_STATUS, 8'h01);
		wr(`ADDR_FLAGS, 8'h07);
		run(8'h81);
		rd(`ADDR_STATUS, 8'h00);
		rd(`ADDR_FLAGS, 8'h06);
		chk({5'h00, cflg, ovf}, 8'h06);
		wr(`ADDR_CTRL, 8'h33);
		run(8'h7F);
		run(8'h81);
		rd(`ADDR_STATUS, 8'h01);
		chk({7'h00, pin[0]}, 8'h01);
	endtask

	// top taken from compare A; loads happen at the wrap
	task automatic t_top7;
		wr(`ADDR_CTRL, 8'h07);
		wr(`ADDR_CMP_A, 8'h04);
		wr(`ADDR_CMP_B, 8'h02);
		wr(`ADDR_COUNT, 8'h7F);
		run(2);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_STATUS, 8'h01);
		wr(`ADDR_CTRL, 8'h47);
		// force is refused in fast modes, else channel B would end low
		wr(`ADDR_FORCE, 8'h02);
		run(5);
		rd(`ADDR_COUNT, 8'h00);
		rd(`ADDR_STATUS, 8'h03);
	endtask

	task automatic close_out;
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		tick = 1'b0;
		bus = '0;
		pval = 2'b11;
		pdir = 2'b01;
		failures = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_pin;
		t_norm;
		t_ctc;
		t_fast;
		t_top7;
		close_out;
	end

	// whole run needs about 500 cycles
	initial
	begin
		#100000;
		failures++;
		close_out;
	end
endmodule
